// [hw/edb_bridge.sv]
// Parallel-port DMA handshake bridge with on-chip buffer DMA
`timescale 1ns/1ns
`default_nettype none
`include "edb_consts.svh"
module edb_bridge
    import edb_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Foreground configuration
    input wire edb_cfg_t cfg,
    output logic busy,
    // Buffer fill port
    input wire logic fill_en,
    input wire logic [MEM_AW-1:0] fill_addr,
    input wire logic [`EDB_WORD_W-1:0] fill_data,
    // Port controller handshake
    input wire logic request_interrupt_input,
    input wire logic xfer_direction,
    output logic xfer_grant,
    output logic final_count_flag,
    output logic [3:0] address_attribute_select_n,
    // Memory port strobes toward the controller
    output logic [`EDB_ADDR_W-1:0] port_addr,
    output edb_byte_t port_byte,
    output logic port_wr_n,
    output logic port_rd_n,
    input wire logic port_ready,
    input wire logic [`EDB_BYTE_W-1:0] port_rd_data
);
    typedef struct packed {
        edb_state_t st;
        logic dir_rev;
        logic [`EDB_ADDR_W-1:0] addr;
        logic [`EDB_CNT_W-1:0] left;
        logic half;
        logic [`EDB_BYTE_W-1:0] test_byte;
        logic grant;
        logic fin;
        logic [`EDB_CS_SEL_W-1:0] cs;
        logic [`EDB_WORD_W-1:0] word;
        logic rd_pend;
        logic strobe;
        logic [`EDB_BYTE_W-1:0] out_byte;
        logic [`EDB_ADDR_W-1:0] out_addr;
        logic req_q;
    } edb_regs_t;

    edb_regs_t r_q, r_d;
    logic [`EDB_WORD_W-1:0] mem_q;
    logic mem_rd;
    logic mem_wr;
    logic [`EDB_WORD_W-1:0] mem_wdata;

    function automatic logic [3:0] cs_decode(input logic [`EDB_CS_SEL_W-1:0] sel, input logic on);
        logic [3:0] m;
        m = `EDB_CS_ALL_OFF;
        if (on) begin
            m = ~(4'h1 << sel);
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    edb_buf_mem #(.ADDR_W(MEM_AW), .WORD_W(`EDB_WORD_W)) u_mem (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .rd_en(mem_rd),
        .rd_addr(r_q.addr[MEM_AW-1:0]),
        .rd_data(mem_q),
        .wr_en(mem_wr),
        .wr_addr(mem_wr && !fill_en ? r_q.addr[MEM_AW-1:0] : fill_addr),
        .wr_data(mem_wdata)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_d = r_q;
        r_d.strobe = 1'b0;
        r_d.req_q = request_interrupt_input;
        mem_rd = 1'b0;
        mem_wr = fill_en;
        mem_wdata = fill_data;
        unique case (r_q.st)
            EDB_IDLE: begin
                // Rising edge acts as the interrupt; direction sampled at once
                if (request_interrupt_input && !r_q.req_q) begin
                    r_d.dir_rev = xfer_direction;
                    r_d.st = EDB_ARM;
                end
            end
            EDB_ARM: begin
                // Channel programmed and grant raised together, on the same edge
                r_d.addr = cfg.start_addr;
                r_d.left = cfg.word_count;
                r_d.cs = cfg.cs_sel;
                r_d.half = 1'b0;
                r_d.test_byte = `EDB_ZERO_BYTE;
                r_d.rd_pend = 1'b0;
                r_d.grant = 1'b1;
                r_d.st = (cfg.word_count == `EDB_ZERO_CNT) ? EDB_DONE : EDB_READ;
            end
            EDB_READ: begin
                if (r_q.dir_rev == `EDB_DIR_REVERSE) begin
                    if (!r_q.rd_pend && !r_q.half) begin
                        mem_rd = 1'b1;
                        r_d.rd_pend = 1'b1;
                    end else begin
                        r_d.rd_pend = 1'b0;
                        if (!r_q.half) begin
                            r_d.word = mem_q;
                        end
                        r_d.st = EDB_SEND;
                    end
                end else begin
                    r_d.st = EDB_SEND;
                end
            end
            EDB_SEND: begin
                r_d.strobe = 1'b1;
                r_d.out_addr = r_q.addr;
                unique case (cfg.pack_mode)
                    EDB_PACK_TEST: r_d.out_byte = r_q.test_byte;
                    EDB_PACK_TWO: r_d.out_byte = r_q.half ? r_q.word[`EDB_HI_MSB:`EDB_HI_LSB]
                                                          : r_q.word[`EDB_BYTE_W-1:0];
                    default: r_d.out_byte = r_q.word[`EDB_BYTE_W-1:0];
                endcase
                if (port_ready) begin
                    r_d.strobe = 1'b0;
                    // Fill owns the write port; a byte colliding with a fill is dropped
                    if (r_q.dir_rev != `EDB_DIR_REVERSE && !fill_en) begin
                        mem_wr = 1'b1;
                        mem_wdata = {{(`EDB_WORD_W-`EDB_BYTE_W){1'b0}}, port_rd_data};
                    end
                    if (cfg.pack_mode == EDB_PACK_TEST) begin
                        // Test stream never ends on its own
                        r_d.test_byte = r_q.test_byte + `EDB_ONE_BYTE;
                        r_d.st = EDB_SEND;
                    end else if (cfg.pack_mode == EDB_PACK_TWO && !r_q.half
                                 && r_q.dir_rev == `EDB_DIR_REVERSE) begin
                        r_d.half = 1'b1;
                        r_d.st = EDB_READ;
                    end else begin
                        r_d.half = 1'b0;
                        r_d.addr = r_q.addr + `EDB_ONE_CNT;
                        r_d.left = r_q.left - `EDB_ONE_CNT;
                        r_d.st = (r_q.left == `EDB_ONE_CNT) ? EDB_DONE : EDB_READ;
                    end
                end
            end
            EDB_DONE: begin
                // Final count pulses with grant drop; channel cleared
                r_d.fin = 1'b1;
                r_d.grant = 1'b0;
                r_d.left = `EDB_ZERO_CNT;
                r_d.addr = `EDB_ZERO_ADDR;
                r_d.st = EDB_IDLE;
            end
        endcase
        if (r_q.st != EDB_DONE) begin
            r_d.fin = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign xfer_grant = r_q.grant;
    assign final_count_flag = r_q.fin;
    assign address_attribute_select_n = cs_decode(r_q.cs, r_q.grant);
    assign busy = (r_q.st != EDB_IDLE);
    assign port_addr = r_q.out_addr;
    assign port_byte = '{data: r_q.out_byte, valid: r_q.strobe, dir_reverse: r_q.dir_rev};
    assign port_wr_n = !(r_q.strobe && r_q.dir_rev);
    assign port_rd_n = !(r_q.strobe && !r_q.dir_rev);

    ////////////////////////////////////////////////////////////////////////
    property p_grant_after_arm;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && r_q.st == EDB_ARM |=> xfer_grant;
    endproperty
    a_grant_after_arm: assert property (p_grant_after_arm) else $error("grant missing after arm");

    property p_strobe_needs_grant;
        @(posedge ref_clk) disable iff (!rst_n)
        r_q.strobe |-> xfer_grant && address_attribute_select_n != `EDB_CS_ALL_OFF;
    endproperty
    a_strobe_needs_grant: assert property (p_strobe_needs_grant) else $error("strobe without grant");

    property p_cs_one_hot;
        @(posedge ref_clk) disable iff (!rst_n)
        xfer_grant |-> $countones(~address_attribute_select_n) == 1;
    endproperty
    a_cs_one_hot: assert property (p_cs_one_hot) else $error("chip select not single");

    property p_fin_drops_grant;
        @(posedge ref_clk) disable iff (!rst_n)
        final_count_flag |-> !xfer_grant;
    endproperty
    a_fin_drops_grant: assert property (p_fin_drops_grant) else $error("grant high with final count");

    property p_fin_after_done;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && r_q.st == EDB_DONE |=> final_count_flag && r_q.left == `EDB_ZERO_CNT;
    endproperty
    a_fin_after_done: assert property (p_fin_after_done) else $error("final count or reset missing");

    property p_fin_one_cycle;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && final_count_flag |=> !final_count_flag;
    endproperty
    a_fin_one_cycle: assert property (p_fin_one_cycle) else $error("final count too long");

    property p_dir_sampled;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && r_q.st == EDB_IDLE && request_interrupt_input && !r_q.req_q
            |=> r_q.st == EDB_ARM && r_q.dir_rev == $past(xfer_direction);
    endproperty
    a_dir_sampled: assert property (p_dir_sampled) else $error("direction not sampled");

    property p_test_inc;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && r_q.st == EDB_SEND && port_ready && cfg.pack_mode == EDB_PACK_TEST
            |=> r_q.test_byte == $past(r_q.test_byte) + `EDB_ONE_BYTE;
    endproperty
    a_test_inc: assert property (p_test_inc) else $error("test byte not incremented");

    property p_busy_flag;
        @(posedge ref_clk) disable iff (!rst_n)
        xfer_grant |-> busy;
    endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("busy low during transfer");

    c_reverse: cover property (@(posedge ref_clk) disable iff (!rst_n) r_q.st == EDB_ARM && r_q.dir_rev);
    c_forward: cover property (@(posedge ref_clk) disable iff (!rst_n) r_q.st == EDB_ARM && !r_q.dir_rev);
    c_two_byte: cover property (@(posedge ref_clk) disable iff (!rst_n) r_q.half && r_q.strobe);
    c_finish: cover property (@(posedge ref_clk) disable iff (!rst_n) final_count_flag);
endmodule
`default_nettype wire

// [hw/edb_consts.svh]
// Constants for the parallel-port DMA handshake bridge
`ifndef EDB_CONSTS_SVH
`define EDB_CONSTS_SVH
`define EDB_ADDR_W 16
`define EDB_WORD_W 24
`define EDB_CNT_W 16
`define EDB_BYTE_W 8
`define EDB_CS_SEL_W 2
`define EDB_DIR_REVERSE 1'b1
`define EDB_ONE_CNT 16'h0001
`define EDB_ZERO_CNT 16'h0000
`define EDB_ZERO_ADDR 16'h0000
`define EDB_ZERO_BYTE 8'h00
`define EDB_ONE_BYTE 8'h01
`define EDB_ZERO_WORD 24'h000000
`define EDB_HI_LSB 8
`define EDB_HI_MSB 15
`define EDB_CS_ALL_OFF 4'hf
`define EDB_CS_ONE_LOW 4'he
`endif

// [hw/edb_pkg.sv]
// Types for the parallel-port DMA handshake bridge
`include "edb_consts.svh"
package edb_pkg;
    typedef enum logic [2:0] {
        EDB_IDLE,
        EDB_ARM,
        EDB_READ,
        EDB_SEND,
        EDB_DONE
    } edb_state_t;
    typedef enum logic [1:0] {
        EDB_PACK_LOW,
        EDB_PACK_TWO,
        EDB_PACK_TEST
    } edb_pack_t;
    typedef struct packed {
        logic [`EDB_ADDR_W-1:0] start_addr;
        logic [`EDB_CNT_W-1:0] word_count;
        edb_pack_t pack_mode;
        logic [`EDB_CS_SEL_W-1:0] cs_sel;
    } edb_cfg_t;
    typedef struct packed {
        logic [`EDB_BYTE_W-1:0] data;
        logic valid;
        logic dir_reverse;
    } edb_byte_t;
endpackage

// [hw/edb_buf_mem.sv]
// Word memory for the transfer buffer with registered read data
`timescale 1ns/1ns
`default_nettype none
module edb_buf_mem #(
    parameter int ADDR_W = 8,
    parameter int WORD_W = 24
) (
    // Clock
    input wire logic ref_clk,
    input wire logic clk_en,
    // Read port
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data,
    // Write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WORD_W-1:0] wr_data
);
    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
    // No reset on the array so it maps onto block memory
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            if (rd_en) begin
                rd_data <= mem[rd_addr];
            end
        end
    end
endmodule
`default_nettype wire

// [sim/edb_port_ctrl_model.sv]
// Behavioural model of the parallel-port controller facing the bridge
`timescale 1ns/1ns
`default_nettype none
module edb_port_ctrl_model
    import edb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bench control
    input wire logic go,
    input wire logic go_dir,
    input wire logic [3:0] slow,
    output logic [15:0] err_cnt,
    output logic [15:0] rx_cnt,
    // Bridge side
    output logic request_interrupt_input,
    output logic xfer_direction,
    input wire logic xfer_grant,
    input wire edb_byte_t port_byte,
    input wire logic port_wr_n,
    input wire logic port_rd_n,
    output logic port_ready,
    output logic [7:0] port_rd_data
);
    logic [3:0] wait_q;
    logic [7:0] fwd_q;
    logic [7:0] prev_q;
    logic strobe;
    assign strobe = !port_wr_n || !port_rd_n;
    assign port_ready = strobe && wait_q == 4'h0;
    // Released bus shows the inverse so a stale byte never passes
    assign port_rd_data = !port_rd_n ? fwd_q : ~fwd_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            request_interrupt_input <= 1'b0;
            xfer_direction <= 1'b0;
            wait_q <= 4'h0;
            fwd_q <= 8'h40;
            prev_q <= 8'h00;
            err_cnt <= 16'h0000;
            rx_cnt <= 16'h0000;
        end else begin
            if (go) begin
                request_interrupt_input <= 1'b1;
                xfer_direction <= go_dir;
                rx_cnt <= 16'h0000;
                err_cnt <= 16'h0000;
            end else if (xfer_grant) begin
                request_interrupt_input <= 1'b0;
            end
            // Each byte waits slow cycles, so prompt and slow answers both occur
            wait_q <= (!strobe || port_ready) ? slow : wait_q - 4'h1;
            if (port_ready && !port_wr_n) begin
                rx_cnt <= rx_cnt + 16'h0001;
                prev_q <= port_byte.data;
                if (rx_cnt != 16'h0000 && port_byte.data !== prev_q + 8'h01) begin
                    err_cnt <= err_cnt + 16'h0001;
                end
            end
            if (port_ready && !port_rd_n) begin
                fwd_q <= fwd_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/ecp_dma_handshake_bridge_tb_top.sv]
// Self-checking bench for the parallel-port DMA handshake bridge
`timescale 1ns/1ns
`default_nettype none
module ecp_dma_handshake_bridge_tb_top
    import edb_pkg::*;
;
    typedef struct {edb_pack_t m; logic [15:0] n; logic [15:0] a;} edb_row_t;
    edb_row_t rows[4] = '{'{EDB_PACK_LOW, 16'h0002, 16'h0000}, '{EDB_PACK_TWO, 16'h0002, 16'h0003},
                          '{EDB_PACK_LOW, 16'h0000, 16'h0000}, '{EDB_PACK_LOW, 16'h0001, 16'h0007}};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    edb_cfg_t cfg;
    logic busy, fill_en, req, dir, grant, fin, wr_n, rd_n, ready, go, go_dir;
    logic [7:0] fill_addr, rd_data;
    logic [23:0] fill_data;
    logic [3:0] cs_n, slow;
    logic [15:0] port_addr, err_cnt, rx_cnt;
    edb_byte_t port_byte;
    int fails = 0;
    int checked = 0;
    int nb = 0;
    logic [15:0] exp_a;
    logic [7:0] got_q[$];
    logic [7:0] exp_q[$];
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    edb_bridge #(.MEM_AW(8)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cfg(cfg), .busy(busy),
        .fill_en(fill_en), .fill_addr(fill_addr), .fill_data(fill_data), .request_interrupt_input(req),
        .xfer_direction(dir), .xfer_grant(grant), .final_count_flag(fin), .address_attribute_select_n(cs_n),
        .port_addr(port_addr), .port_byte(port_byte), .port_wr_n(wr_n), .port_rd_n(rd_n), .port_ready(ready),
        .port_rd_data(rd_data));
    edb_port_ctrl_model i_peer (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .go_dir(go_dir), .slow(slow),
        .err_cnt(err_cnt), .rx_cnt(rx_cnt), .request_interrupt_input(req), .xfer_direction(dir),
        .xfer_grant(grant), .port_byte(port_byte), .port_wr_n(wr_n), .port_rd_n(rd_n), .port_ready(ready),
        .port_rd_data(rd_data));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] wd(input logic [7:0] i);
        return {8'ha0 + i, 8'h30 + i, 8'h10 + i};
    endfunction
    task automatic print_verdict();
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo(input bit hit);
        if (hit) begin
            fails++;
            print_verdict();
        end
    endtask
    // Accepted bytes, sampled before the edge's updates land; test stream holds one address
    always @(posedge ref_clk) begin
        if (port_byte.valid === 1'b1) cmp1(grant, 1'b1);
        if (port_byte.valid === 1'b1 && ready && port_byte.dir_reverse) got_q.push_back(port_byte.data);
        if (port_byte.valid === 1'b1 && ready === 1'b1 && cfg.pack_mode != EDB_PACK_TEST) begin
            exp_a = cfg.start_addr + 16'((cfg.pack_mode == EDB_PACK_TWO && port_byte.dir_reverse) ? nb / 2 : nb);
            cmp(port_addr, exp_a);
            nb++;
        end
    end
    task automatic start(input edb_pack_t m, input logic [15:0] n, input logic [15:0] a, input logic [1:0] cs,
                         input logic d, input logic [3:0] s);
        got_q.delete();
        nb = 0;
        @(posedge ref_clk);
        cfg <= '{start_addr: a, word_count: n, pack_mode: m, cs_sel: cs};
        slow <= s;
        go_dir <= d;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask
    task automatic wait_end(input logic [1:0] cs);
        int k;
        k = 0;
        do begin @(negedge ref_clk); k++; end while (grant !== 1'b1 && k < 50);
        tmo(k >= 50);
        cmp(cs_n, 4'(~(4'h1 << cs)));
        k = 0;
        while (fin !== 1'b1 && k < 600) begin @(negedge ref_clk); k++; end
        tmo(k >= 600);
        cmp1(grant, 1'b0);
        cmp(cs_n, 4'hf);
        @(negedge ref_clk);
        cmp1(fin, 1'b0);
        cmp1(busy, 1'b0);
        cmp(16'(got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) cmp(got_q[i], exp_q[i]);
    endtask
    task automatic xfer(input edb_pack_t m, input logic [15:0] n, input logic [15:0] a, input logic [1:0] cs,
                        input logic d, input logic [3:0] s);
        start(m, n, a, cs, d, s);
        wait_end(cs);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] w;
        int k;
        cfg = '0;
        fill_en = 1'b0;
        fill_addr = 8'h00;
        fill_data = 24'h000000;
        go = 1'b0;
        go_dir = 1'b0;
        slow = 4'h0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            fill_en <= 1'b1;
            fill_addr <= i[7:0];
            fill_data <= wd(i[7:0]);
        end
        @(posedge ref_clk);
        fill_en <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            exp_q.delete();
            for (int j = 0; j < rows[r].n; j++) begin
                w = wd(rows[r].a[7:0] + j[7:0]);
                exp_q.push_back(w[7:0]);
                if (rows[r].m == EDB_PACK_TWO) exp_q.push_back(w[15:8]);
            end
            xfer(rows[r].m, rows[r].n, rows[r].a, r[1:0], 1'b1, 4'(r * 2));
        end
        // Forward fill, then read back in reverse
        exp_q.delete();
        xfer(EDB_PACK_LOW, 16'h0002, 16'h0010, 2'h1, 1'b0, 4'h3);
        exp_q = '{8'h40, 8'h41};
        xfer(EDB_PACK_LOW, 16'h0002, 16'h0010, 2'h2, 1'b1, 4'h0);
        // Endless test stream; only a reset stops it
        start(EDB_PACK_TEST, 16'h0001, 16'h0000, 2'h0, 1'b1, 4'h0);
        k = 0;
        while (rx_cnt < 16'h0014 && k < 500) begin @(negedge ref_clk); k++; end
        tmo(k >= 500);
        cmp(err_cnt, 16'h0000);
        cmp(got_q[0], 8'h00);
        cmp1(fin, 1'b0);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(negedge ref_clk);
        cmp1(grant, 1'b0);
        cmp1(fin, 1'b0);
        cmp(cs_n, 4'hf);
        cmp1(busy, 1'b0);
        // Restart with the enable low: the pending request must wait for it
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        clk_en <= 1'b0;
        exp_q = '{8'h10};
        start(EDB_PACK_LOW, 16'h0001, 16'h0000, 2'h3, 1'b1, 4'h1);
        repeat (4) @(negedge ref_clk);
        cmp1(grant, 1'b0);
        cmp1(busy, 1'b0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        wait_end(2'h3);
        print_verdict();
    end
endmodule
`default_nettype wire
